/* core/scp_pkg.sv */
// constants, field layouts and carrier types for the system control ports
package scp_pkg;
  // processor i/o addresses
  localparam logic [7:0] SCP_PPI_PORT_A_OUT      = 8'hE0;
  localparam logic [7:0] SCP_PPI_PORT_B_IN       = 8'hE1;
  localparam logic [7:0] SCP_PPI_PORT_C_OUT      = 8'hE2;
  localparam logic [7:0] SCP_PPI_MODE_CONTROL    = 8'hE3;
  localparam logic [7:0] SCP_TIMER_COUNT_0       = 8'hE4;
  localparam logic [7:0] SCP_TIMER_COUNT_1       = 8'hE5;
  localparam logic [7:0] SCP_TIMER_COUNT_2       = 8'hE6;
  localparam logic [7:0] SCP_TIMER_MODE_CONTROL  = 8'hE7;
  localparam logic [7:0] SCP_PIO_PORT_A_DATA     = 8'hE8;
  localparam logic [7:0] SCP_PIO_PORT_A_CONTROL  = 8'hE9;
  localparam logic [7:0] SCP_PIO_PORT_B_DATA     = 8'hEA;
  localparam logic [7:0] SCP_PIO_PORT_B_CONTROL  = 8'hEB;
  localparam logic [7:0] SCP_WO_READ_VALUE       = 8'hFF;
  localparam logic [7:0] SCP_OUT_PORT_RESET      = 8'h00;
  // timing: 31.25 kHz timer input derived from the 100 MHz system clock
  localparam int         SCP_CLK_HZ              = 100000000;
  localparam int         SCP_TICK_HZ             = 31250;
  localparam int         SCP_TICK_CYCLES         = SCP_CLK_HZ / SCP_TICK_HZ;
  // field positions
  localparam int         SCP_PPI_MODESET_BIT     = 7;
  localparam int         SCP_TMR_SEL_LSB         = 6;
  localparam int         SCP_TMR_RW_LSB          = 4;
  localparam int         SCP_TMR_MODE_LSB        = 1;
  localparam int         SCP_PIO_MODE_LSB        = 6;
  localparam int         SCP_PIO_ICW_MASK_BIT    = 4;
  localparam logic [3:0] SCP_PIO_MODE_WORD       = 4'hF;
  localparam logic [3:0] SCP_PIO_ICW_WORD        = 4'h7;
  localparam logic [1:0] SCP_PIO_MODE_OUT        = 2'd0;
  localparam logic [1:0] SCP_PIO_MODE_IN         = 2'd1;
  localparam logic [1:0] SCP_PIO_MODE_BIT        = 2'd3;
  localparam logic [7:0] SCP_PIO_DIR_RESET       = 8'hFF;
  localparam logic [1:0] SCP_TMR_RW_LATCH        = 2'd0;
  localparam logic [1:0] SCP_TMR_RW_LSB_ONLY     = 2'd1;
  localparam logic [1:0] SCP_TMR_RW_MSB_ONLY     = 2'd2;
  localparam logic [1:0] SCP_TMR_RW_BOTH         = 2'd3;
  localparam logic [1:0] SCP_TMR_RW_RESET        = 2'd3;
  localparam logic [2:0] SCP_TMR_MODE_RATE       = 3'd2;
  localparam int         SCP_KEY_ROWS            = 12;

  typedef enum logic [2:0] {
    SCP_PIO_EXPECT_CTRL = 3'b001,
    SCP_PIO_EXPECT_DIR  = 3'b010,
    SCP_PIO_EXPECT_MASK = 3'b100
  } scp_pio_state_t;

  // lamp_cassette_out_port, bit 7 first
  typedef struct packed {
    logic reverse_lamp;
    logic graphic_lamp;
    logic shift_lock_lamp;
    logic screen_invert_n;
    logic tape_stop;
    logic tape_play;
    logic fast_forward;
    logic reel_motor;
  } scp_lamp_cassette_t;

  // cassette_status_in_port, bit 7 first
  typedef struct packed {
    logic       break_in_play;
    logic       tape_read_data;
    logic       cassette_loaded_n;
    logic       write_protect_n;
    logic [2:0] spare;
    logic       blanking;
  } scp_cassette_status_t;

  // cassette_memmap_out_port, bit 7 first
  typedef struct packed {
    logic tape_write_data;
    logic head_read;
    logic wind_latch;
    logic eject_n;
    logic initial_program_load_n;
    logic sound_pulse;
    logic normal_map;
    logic force_blank;
  } scp_cassette_memmap_t;
endpackage : scp_pkg

/* core/scp_system_ctrl.sv */
// system control ports: parallel interface, clock timer chain, keyboard/video controller
`timescale 1ns/1ps
`default_nettype none

// Operation
// - decode E0-E3, E4-E7, E8-EB to three units
// - three 16-bit auto-reloading rate generators
// - counter 0 counts 31.25 kHz, pulses each second
// - counter 1 counts counter 0 pulses
// - counter 2 output toggles as meridiem flag
// - port A bits 7-5 light keyboard lamps
// - port A bit 4 low inverts screen
// - port A bits 3-0 steer cassette deck
// - port B bits 7-4 report cassette status
// - port B bit 0 blanking, bits 3-1 spare
// - port C bit 7 tape data, bit 6 head
// - port C bit 5 wind latch, bit 4 eject
// - port C bit 3 loader, bit 1 normal map
// - port C bit 2 drives sound pulse
// - port C bit 0 forces display blank
// - controller A outputs, B inputs, bit mode
// - controller A bits 7-6 map video memory
// - controller A bit 5 selects 80 columns
// - controller A bit 4 low drops all strobes
// - controller A bits 3-0 give scan row
// - controller B reads selected row key data
// - scan value decoded to 12 row strobes
module scp_system_ctrl (
  input  wire  logic                          mclk_in,          // 100 MHz system clock
  input  wire  logic                          srst_in,          // synchronous reset, high
  input  wire  logic [7:0]                    io_addr_in,       // low i/o address byte
  input  wire  logic [7:0]                    io_wdata_in,      // write data
  input  wire  logic                          io_wr_in,         // one-cycle write strobe
  input  wire  logic                          io_rd_in,         // one-cycle read strobe
  output logic [7:0]                          io_rdata_out,     // read data, next cycle
  output logic                                io_hit_out,       // read decoded here
  input  wire  scp_pkg::scp_cassette_status_t cassette_status_in_port, // status pins
  input  wire  logic [7:0]                    key_data_in,      // keyboard row data pins
  output scp_pkg::scp_lamp_cassette_t         lamp_cassette_out_port,   // lamps, deck
  output scp_pkg::scp_cassette_memmap_t       cassette_memmap_out_port, // tape, map
  output logic                                seconds_pulse_out,   // counter 0 pulse
  output logic                                half_day_pulse_out,  // counter 1 pulse
  output logic                                meridiem_flag_out,   // counter 2 output
  output logic                                vram_high_map_out,   // D000-FFFF to video
  output logic                                vram_low_map_out,    // video at 5000-7FFF
  output logic                                wide_text_out,       // 80 columns
  output logic [11:0]                         key_row_strobe_out   // low selects row
);
  import scp_pkg::*;

  // ---------------- pin synchronisers ----------------
  logic [7:0] status_meta_reg;
  logic [7:0] status_sync_reg;
  logic [7:0] key_meta_reg;
  logic [7:0] key_sync_reg;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      status_meta_reg <= 8'h00;
      status_sync_reg <= 8'h00;
      key_meta_reg    <= 8'h00;
      key_sync_reg    <= 8'h00;
    end else begin
      status_meta_reg <= cassette_status_in_port;
      status_sync_reg <= status_meta_reg;
      key_meta_reg    <= key_data_in;
      key_sync_reg    <= key_meta_reg;
    end
  end

  // ---------------- address decode ----------------
  logic wr_ppi_a, wr_ppi_c, wr_ppi_ctl, wr_tmr_ctl, wr_pio_a;
  logic in_range;

  assign in_range   = io_addr_in >= SCP_PPI_PORT_A_OUT &&
                      io_addr_in <= SCP_PIO_PORT_B_CONTROL;
  assign wr_ppi_a   = io_wr_in && io_addr_in == SCP_PPI_PORT_A_OUT;
  assign wr_ppi_c   = io_wr_in && io_addr_in == SCP_PPI_PORT_C_OUT;
  assign wr_ppi_ctl = io_wr_in && io_addr_in == SCP_PPI_MODE_CONTROL;
  assign wr_tmr_ctl = io_wr_in && io_addr_in == SCP_TIMER_MODE_CONTROL;
  assign wr_pio_a   = io_wr_in && io_addr_in == SCP_PIO_PORT_A_DATA;

  // ---------------- three-port interface ----------------
  logic [7:0] ppi_mode_reg;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      lamp_cassette_out_port   <= SCP_OUT_PORT_RESET;
      cassette_memmap_out_port <= SCP_OUT_PORT_RESET;
      ppi_mode_reg             <= SCP_OUT_PORT_RESET;
    end else if (wr_ppi_a) begin
      lamp_cassette_out_port   <= io_wdata_in;
    end else if (wr_ppi_c) begin
      cassette_memmap_out_port <= io_wdata_in;
    end else if (wr_ppi_ctl) begin
      if (io_wdata_in[SCP_PPI_MODESET_BIT]) begin
        // a mode set word clears the output latches, as the port chip does
        ppi_mode_reg             <= io_wdata_in;
        lamp_cassette_out_port   <= SCP_OUT_PORT_RESET;
        cassette_memmap_out_port <= SCP_OUT_PORT_RESET;
      end else begin
        // single bit set/reset lets software toggle the sound bit cheaply
        cassette_memmap_out_port[io_wdata_in[3:1]] <= io_wdata_in[0];
      end
    end
  end

  // ---------------- timer chain ----------------
  logic [11:0] tick_div_reg;
  logic        tick_reg;
  // the divider runs freely from reset, so a new count meets its first tick at any phase

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tick_div_reg <= 12'h000;
      tick_reg     <= 1'b0;
    end else if (tick_div_reg == 12'(SCP_TICK_CYCLES - 1)) begin
      tick_div_reg <= 12'h000;
      tick_reg     <= 1'b1;
    end else begin
      tick_div_reg <= tick_div_reg + 12'h001;
      tick_reg     <= 1'b0;
    end
  end

  logic [15:0] cnt_reg    [3];
  logic [15:0] reload_reg [3];
  logic [15:0] latch_reg  [3];
  logic [1:0]  rw_reg     [3];
  logic [2:0]  tmode_reg  [3];
  logic [2:0]  loaded_reg;
  logic [2:0]  latched_reg;
  logic [2:0]  wr_hi_reg;
  logic [2:0]  rd_hi_reg;
  logic [2:0]  tmr_en;
  logic [2:0]  tmr_pulse;

  assign tmr_en = {half_day_pulse_out, seconds_pulse_out, tick_reg};

  // picks the byte a counter access touches under its read/write format
  function automatic logic [7:0] tmr_byte(input logic [1:0] rw, input logic hi,
                                          input logic [15:0] v);
    logic msb;
    msb = (rw == SCP_TMR_RW_MSB_ONLY) || (rw == SCP_TMR_RW_BOTH && hi);
    return msb ? v[15:8] : v[7:0];
  endfunction : tmr_byte

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // a count of 1 ends the period; 0 stands for 65536
      tmr_pulse[i] = tmr_en[i] && loaded_reg[i] && cnt_reg[i] == 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 3; i++) begin
        cnt_reg[i]    <= 16'h0000;
        reload_reg[i] <= 16'h0000;
        latch_reg[i]  <= 16'h0000;
        rw_reg[i]     <= SCP_TMR_RW_RESET;
        tmode_reg[i]  <= SCP_TMR_MODE_RATE;
      end
      loaded_reg  <= 3'b000;
      latched_reg <= 3'b000;
      wr_hi_reg   <= 3'b000;
      rd_hi_reg   <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tmr_pulse[i]) begin
          cnt_reg[i] <= reload_reg[i];
        end else if (tmr_en[i] && loaded_reg[i]) begin
          cnt_reg[i] <= cnt_reg[i] - 16'h0001;
        end
        if (io_wr_in && io_addr_in == SCP_TIMER_COUNT_0 + 8'(i)) begin
          case (rw_reg[i])
            SCP_TMR_RW_LSB_ONLY: begin
              reload_reg[i] <= {8'h00, io_wdata_in};
              cnt_reg[i]    <= {8'h00, io_wdata_in};
              loaded_reg[i] <= 1'b1;
            end
            SCP_TMR_RW_MSB_ONLY: begin
              reload_reg[i] <= {io_wdata_in, 8'h00};
              cnt_reg[i]    <= {io_wdata_in, 8'h00};
              loaded_reg[i] <= 1'b1;
            end
            default: begin
              // counting halts between the two bytes of a new count
              if (wr_hi_reg[i]) begin
                reload_reg[i] <= {io_wdata_in, reload_reg[i][7:0]};
                cnt_reg[i]    <= {io_wdata_in, reload_reg[i][7:0]};
                loaded_reg[i] <= 1'b1;
              end else begin
                reload_reg[i][7:0] <= io_wdata_in;
                loaded_reg[i]      <= 1'b0;
              end
              wr_hi_reg[i] <= ~wr_hi_reg[i];
            end
          endcase
        end
        if (io_rd_in && io_addr_in == SCP_TIMER_COUNT_0 + 8'(i)) begin
          if (rw_reg[i] == SCP_TMR_RW_BOTH) begin
            rd_hi_reg[i] <= ~rd_hi_reg[i];
          end
          if (rw_reg[i] != SCP_TMR_RW_BOTH || rd_hi_reg[i]) begin
            latched_reg[i] <= 1'b0;
          end
        end
        if (wr_tmr_ctl && io_wdata_in[SCP_TMR_SEL_LSB +: 2] == 2'(i)) begin
          if (io_wdata_in[SCP_TMR_RW_LSB +: 2] == SCP_TMR_RW_LATCH) begin
            if (!latched_reg[i]) begin
              latch_reg[i]   <= cnt_reg[i];
              latched_reg[i] <= 1'b1;
            end
          end else begin
            // every counter runs as a rate generator; the mode field is only kept
            rw_reg[i]      <= io_wdata_in[SCP_TMR_RW_LSB +: 2];
            tmode_reg[i]   <= io_wdata_in[SCP_TMR_MODE_LSB +: 3];
            loaded_reg[i]  <= 1'b0;
            latched_reg[i] <= 1'b0;
            wr_hi_reg[i]   <= 1'b0;
            rd_hi_reg[i]   <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      seconds_pulse_out  <= 1'b0;
      half_day_pulse_out <= 1'b0;
      meridiem_flag_out  <= 1'b0;
    end else begin
      seconds_pulse_out  <= tmr_pulse[0];
      half_day_pulse_out <= tmr_pulse[1];
      if (tmr_pulse[2]) begin
        meridiem_flag_out <= ~meridiem_flag_out;
      end
    end
  end

  // ---------------- keyboard / video controller ----------------
  scp_pio_state_t pio_state_reg [2];
  logic [1:0]     pio_mode_reg  [2];
  logic [7:0]     pio_dir_reg   [2];
  logic [7:0]     pio_a_data_reg;
  logic [7:0]     pio_a_drive;
  logic [7:0]     pio_b_read;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pio_a_data_reg <= SCP_OUT_PORT_RESET;
    end else if (wr_pio_a) begin
      pio_a_data_reg <= io_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      for (int p = 0; p < 2; p++) begin
        pio_state_reg[p] <= SCP_PIO_EXPECT_CTRL;
        pio_mode_reg[p]  <= SCP_PIO_MODE_IN;
        pio_dir_reg[p]   <= SCP_PIO_DIR_RESET;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (io_wr_in && io_addr_in == (p == 0 ? SCP_PIO_PORT_A_CONTROL
                                              : SCP_PIO_PORT_B_CONTROL)) begin
          case (pio_state_reg[p])
            SCP_PIO_EXPECT_CTRL: begin
              if (io_wdata_in[3:0] == SCP_PIO_MODE_WORD) begin
                pio_mode_reg[p] <= io_wdata_in[SCP_PIO_MODE_LSB +: 2];
                if (io_wdata_in[SCP_PIO_MODE_LSB +: 2] == SCP_PIO_MODE_BIT) begin
                  pio_state_reg[p] <= SCP_PIO_EXPECT_DIR;
                end
              end else if (io_wdata_in[3:0] == SCP_PIO_ICW_WORD &&
                           io_wdata_in[SCP_PIO_ICW_MASK_BIT]) begin
                // interrupt logic is not built; its mask byte is swallowed
                pio_state_reg[p] <= SCP_PIO_EXPECT_MASK;
              end
            end
            SCP_PIO_EXPECT_DIR: begin
              pio_dir_reg[p]   <= io_wdata_in;
              pio_state_reg[p] <= SCP_PIO_EXPECT_CTRL;
            end
            SCP_PIO_EXPECT_MASK: begin
              pio_state_reg[p] <= SCP_PIO_EXPECT_CTRL;
            end
            default: begin
              pio_state_reg[p] <= SCP_PIO_EXPECT_CTRL;
            end
          endcase
        end
      end
    end
  end

  // bits set as inputs, or an input-mode port, drive low
  always_comb begin
    case (pio_mode_reg[0])
      SCP_PIO_MODE_OUT: pio_a_drive = pio_a_data_reg;
      SCP_PIO_MODE_BIT: pio_a_drive = pio_a_data_reg & ~pio_dir_reg[0];
      default:          pio_a_drive = 8'h00;
    endcase
  end

  // in bit mode only bits set as inputs carry key data; port b has no output latch to show
  always_comb begin
    case (pio_mode_reg[1])
      SCP_PIO_MODE_BIT: pio_b_read = key_sync_reg & pio_dir_reg[1];
      default:          pio_b_read = key_sync_reg;
    endcase
  end

  // one row low per scan value; values 12 to 15 select no row
  function automatic logic [11:0] row_decode(input logic gate, input logic [3:0] row);
    logic [11:0] lines;
    lines = 12'hFFF;
    if (!gate) begin
      lines = 12'h000;
    end else if (row < 4'(SCP_KEY_ROWS)) begin
      lines[row] = 1'b0;
    end
    return lines;
  endfunction : row_decode

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      vram_high_map_out  <= 1'b0;
      vram_low_map_out   <= 1'b0;
      wide_text_out      <= 1'b0;
      key_row_strobe_out <= 12'h000;
    end else begin
      vram_high_map_out  <= pio_a_drive[7];
      vram_low_map_out   <= pio_a_drive[6];
      wide_text_out      <= pio_a_drive[5];
      key_row_strobe_out <= row_decode(pio_a_drive[4], pio_a_drive[3:0]);
    end
  end

  // ---------------- read path ----------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      io_rdata_out <= 8'h00;
      io_hit_out   <= 1'b0;
    end else begin
      io_hit_out <= io_rd_in && in_range;
      if (io_rd_in) begin
        case (io_addr_in)
          SCP_PPI_PORT_A_OUT:  io_rdata_out <= lamp_cassette_out_port;
          SCP_PPI_PORT_B_IN:   io_rdata_out <= status_sync_reg;
          SCP_PPI_PORT_C_OUT:  io_rdata_out <= cassette_memmap_out_port;
          SCP_TIMER_COUNT_0, SCP_TIMER_COUNT_1, SCP_TIMER_COUNT_2: begin
            io_rdata_out <= tmr_byte(rw_reg[io_addr_in[1:0]], rd_hi_reg[io_addr_in[1:0]],
                                     latched_reg[io_addr_in[1:0]] ?
                                     latch_reg[io_addr_in[1:0]] :
                                     cnt_reg[io_addr_in[1:0]]);
          end
          SCP_PIO_PORT_A_DATA: io_rdata_out <= pio_a_data_reg;
          SCP_PIO_PORT_B_DATA: io_rdata_out <= pio_b_read;
          default:             io_rdata_out <= in_range ? SCP_WO_READ_VALUE : 8'h00;
        endcase
      end
    end
  end

endmodule : scp_system_ctrl
`default_nettype wire

/* sim/scp_far_side_model.sv */
// far side model: keyboard matrix and cassette deck status pins
`timescale 1ns/1ps
`default_nettype none
module scp_far_side_model (
  input  wire logic                     mclk_in,           // system clock
  input  wire logic [11:0]              key_row_strobe_in, // row strobes, low selects
  input  wire logic [7:0]               deck_state_in,     // deck status to present
  output logic [7:0]                    key_data_out,      // key data of selected row
  output scp_pkg::scp_cassette_status_t status_out         // deck status pins
);
  import scp_pkg::*;
  int row;
  always_comb begin
    row = -1;
    for (int i = 0; i < SCP_KEY_ROWS; i++) begin
      if (!key_row_strobe_in[i] && $countones(~key_row_strobe_in) == 1) row = i;
    end
  end
  // pull-ups read all ones unless exactly one row is driven
  assign key_data_out = (row < 0) ? 8'hFF : {4'hA, 4'(row)};
  always_ff @(posedge mclk_in) status_out <= deck_state_in;
endmodule : scp_far_side_model
`default_nettype wire

/* sim/scp_system_ctrl_assertions.sv */
// assertion checker for the system control ports, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module scp_system_ctrl_assertions
  import scp_pkg::*;
(
  input wire logic                          mclk_in,                  // system clock
  input wire logic                          srst_in,                  // sync reset
  input wire logic [7:0]                    io_addr_in,               // i/o address
  input wire logic [7:0]                    io_wdata_in,              // write data
  input wire logic                          io_wr_in,                 // write strobe
  input wire logic                          io_rd_in,                 // read strobe
  input wire logic [7:0]                    io_rdata_out,             // read data
  input wire logic                          io_hit_out,               // decoded read
  input wire scp_pkg::scp_lamp_cassette_t   lamp_cassette_out_port,   // lamps, deck
  input wire scp_pkg::scp_cassette_memmap_t cassette_memmap_out_port, // tape, map
  input wire logic                          seconds_pulse_out,        // counter 0 pulse
  input wire logic                          half_day_pulse_out,       // counter 1 pulse
  input wire logic                          meridiem_flag_out,        // counter 2 flag
  input wire logic [11:0]                   key_row_strobe_out        // row strobes
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  lamp_write_a: assert property (
    io_wr_in && io_addr_in == SCP_PPI_PORT_A_OUT |=> lamp_cassette_out_port == $past(io_wdata_in))
    else $error("lamp port not loaded by its write");
  memmap_write_a: assert property (
    io_wr_in && io_addr_in == SCP_PPI_PORT_C_OUT
    |=> cassette_memmap_out_port == $past(io_wdata_in))
    else $error("memmap port not loaded by its write");
  read_hit_a: assert property (
    io_rd_in && io_addr_in inside {[SCP_PPI_PORT_A_OUT:SCP_PIO_PORT_B_CONTROL]} |=> io_hit_out)
    else $error("decoded read gave no hit");
  read_miss_a: assert property (
    io_rd_in && !(io_addr_in inside {[SCP_PPI_PORT_A_OUT:SCP_PIO_PORT_B_CONTROL]})
    |=> !io_hit_out && io_rdata_out == 8'h00)
    else $error("unmapped read answered");
  port_readback_a: assert property (
    io_rd_in && !io_wr_in && io_addr_in == SCP_PPI_PORT_A_OUT
    |=> io_rdata_out == $past(lamp_cassette_out_port))
    else $error("lamp port readback differs");
  wo_read_a: assert property (
    io_rd_in && io_addr_in inside {8'hE3, 8'hE7, 8'hE9, 8'hEB} |=> io_rdata_out == SCP_WO_READ_VALUE)
    else $error("write-only read not FF");
  bit_setreset_a: assert property (
    io_wr_in && io_addr_in == SCP_PPI_MODE_CONTROL && !io_wdata_in[7]
    |=> cassette_memmap_out_port[$past(io_wdata_in[3:1])] == $past(io_wdata_in[0]))
    else $error("port c bit set or reset lost");
  strobe_row_a: assert property (
    $countones(~key_row_strobe_out) <= 1 || key_row_strobe_out == 12'h000)
    else $error("more than one row strobe low");
  half_day_cause_a: assert property (
    $rose(half_day_pulse_out) |-> $past(seconds_pulse_out) || $past(seconds_pulse_out, 2))
    else $error("half day pulse without seconds pulse");
  meridiem_cause_a: assert property (
    $changed(meridiem_flag_out)
    |-> $past(half_day_pulse_out) || $past(half_day_pulse_out, 2) || $past(half_day_pulse_out, 3))
    else $error("meridiem flag moved without half day pulse");
endmodule : scp_system_ctrl_assertions

bind scp_system_ctrl scp_system_ctrl_assertions u_chk (
  .mclk_in(mclk_in), .srst_in(srst_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
  .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out),
  .io_hit_out(io_hit_out), .lamp_cassette_out_port(lamp_cassette_out_port),
  .cassette_memmap_out_port(cassette_memmap_out_port), .seconds_pulse_out(seconds_pulse_out),
  .half_day_pulse_out(half_day_pulse_out), .meridiem_flag_out(meridiem_flag_out),
  .key_row_strobe_out(key_row_strobe_out));
`default_nettype wire

/* sim/tb_scp_system_ctrl.sv */
// self-checking testbench for the system control ports
`timescale 1ns/1ps
`default_nettype none
module tb_scp_system_ctrl;
  import scp_pkg::*;
  logic                 mclk_in = 1'b0, srst_in = 1'b1, io_wr_in = 1'b0, io_rd_in = 1'b0;
  logic [7:0]           io_addr_in = 8'h00, io_wdata_in = 8'h00, deck_state = 8'h00;
  logic [7:0]           io_rdata_out, key_data, rd, expc, pa;
  logic                 io_hit_out, hit, mer;
  logic                 seconds_pulse_out, half_day_pulse_out, meridiem_flag_out;
  logic                 vram_high_map_out, vram_low_map_out, wide_text_out;
  logic [11:0]          key_row_strobe_out;
  scp_cassette_status_t status;
  scp_lamp_cassette_t   lamp_cassette_out_port;
  scp_cassette_memmap_t cassette_memmap_out_port;
  int                   miscompares = 0, comparisons = 0, n, secs;
  logic [7:0]           vals[3] = '{8'h81, 8'h7E, 8'hA5};
  logic [7:0]           rdaddr[6] = '{8'hE3, 8'hE7, 8'hE9, 8'hEB, 8'hDF, 8'hEC};
  // scaled-down counts keep the run short: one tick a second, two seconds a half day
  logic [15:0]          tmr[9] = '{16'hE774, 16'hE502, 16'hE500, 16'hE7B4, 16'hE601,
                                   16'hE600, 16'hE734, 16'hE401, 16'hE400};

  scp_system_ctrl uut (.mclk_in(mclk_in), .srst_in(srst_in), .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_rdata_out(io_rdata_out), .io_hit_out(io_hit_out), .cassette_status_in_port(status),
    .key_data_in(key_data), .lamp_cassette_out_port(lamp_cassette_out_port),
    .cassette_memmap_out_port(cassette_memmap_out_port), .seconds_pulse_out(seconds_pulse_out),
    .half_day_pulse_out(half_day_pulse_out), .meridiem_flag_out(meridiem_flag_out),
    .vram_high_map_out(vram_high_map_out), .vram_low_map_out(vram_low_map_out),
    .wide_text_out(wide_text_out), .key_row_strobe_out(key_row_strobe_out));
  scp_far_side_model u_far (.mclk_in(mclk_in), .key_row_strobe_in(key_row_strobe_out),
    .deck_state_in(deck_state), .key_data_out(key_data), .status_out(status));

  initial forever #5 mclk_in = ~mclk_in;

  task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
    comparisons++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask : check

  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge mclk_in);
    io_wr_in <= 1'b0;
    #1;
  endtask : io_write

  task automatic io_read(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge mclk_in);
    io_rd_in <= 1'b0;
    #1;
    d = io_rdata_out;
    h = io_hit_out;
  endtask : io_read

  task automatic wait_pulse(input logic half, output int cycles);
    cycles = 0;
    do begin
      @(posedge mclk_in);
      #1;
      cycles++;
      if (seconds_pulse_out === 1'b1) secs++;
    end while ((half ? half_day_pulse_out : seconds_pulse_out) !== 1'b1 && cycles < 20000);
  endtask : wait_pulse

  function automatic logic [11:0] exp_strobe(input logic [7:0] v);
    return !v[4] ? 12'h000 : (v[3:0] > 4'hB) ? 12'hFFF : ~(12'h001 << v[3:0]);
  endfunction : exp_strobe

  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge mclk_in);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    io_read(SCP_PPI_PORT_A_OUT, rd, hit);
    check({rd, key_row_strobe_out[7:0]}, 16'h0000, "reset state");
    foreach (vals[i]) begin
      io_write(SCP_PPI_PORT_A_OUT, vals[i]);
      io_write(SCP_PPI_PORT_C_OUT, ~vals[i]);
      check({lamp_cassette_out_port, cassette_memmap_out_port}, {vals[i], ~vals[i]}, "ports");
      io_read(SCP_PPI_PORT_C_OUT, rd, hit);
      check({7'h00, hit, rd}, {8'h01, ~vals[i]}, "port c readback");
    end
    expc = 8'h00;
    io_write(SCP_PPI_PORT_C_OUT, expc);
    for (int i = 0; i < 16; i++) begin
      expc[i % 8] = (i < 8);
      io_write(SCP_PPI_MODE_CONTROL, {4'h0, 3'(i % 8), 1'(i < 8)});
      check({8'h00, cassette_memmap_out_port}, {8'h00, expc}, "bit set reset");
    end
    io_write(SCP_PPI_PORT_A_OUT, 8'hFF);
    io_write(SCP_PPI_MODE_CONTROL, 8'h80);
    check({lamp_cassette_out_port, cassette_memmap_out_port}, 16'h0000, "mode set");
    foreach (vals[i]) begin
      deck_state <= vals[i];
      io_write(SCP_PPI_PORT_B_IN, ~vals[i]);
      repeat (2) @(posedge mclk_in);
      io_read(SCP_PPI_PORT_B_IN, rd, hit);
      check({8'h00, rd}, {8'h00, vals[i]}, "status port");
    end
    foreach (rdaddr[i]) begin
      io_read(rdaddr[i], rd, hit);
      check({7'h00, hit, rd}, (i < 4) ? 16'h01FF : 16'h0000, "no-data read");
    end
    io_write(SCP_PIO_PORT_A_CONTROL, 8'hCF);
    io_write(SCP_PIO_PORT_A_CONTROL, 8'h00);
    io_write(SCP_PIO_PORT_B_CONTROL, 8'hCF);
    io_write(SCP_PIO_PORT_B_CONTROL, 8'hFF);
    for (int r = 0; r < 17; r++) begin
      pa = (r < 16) ? {3'(r), 1'b1, 4'(r)} : 8'h07;
      io_write(SCP_PIO_PORT_A_DATA, pa);
      repeat (3) @(posedge mclk_in);
      #1;
      check({13'h0, vram_high_map_out, vram_low_map_out, wide_text_out}, {13'h0, pa[7:5]},
            "video controls");
      check({4'h0, key_row_strobe_out}, {4'h0, exp_strobe(pa)}, "row strobes");
      io_read(SCP_PIO_PORT_B_DATA, rd, hit);
      check({8'h00, rd}, (pa[4] && pa[3:0] < 4'hC) ? {12'h00A, pa[3:0]} : 16'h00FF,
            "key data");
    end
    io_read(SCP_PIO_PORT_A_DATA, rd, hit);
    check({8'h00, rd}, 16'h0007, "controller readback");
    foreach (tmr[i]) io_write(tmr[i][15:8], tmr[i][7:0]);
    repeat (2) wait_pulse(1'b0, n);
    check(16'(n), 16'(SCP_TICK_CYCLES), "seconds period");
    wait_pulse(1'b1, n);
    secs = 0;
    repeat (8) @(posedge mclk_in);
    mer = meridiem_flag_out;
    wait_pulse(1'b1, n);
    repeat (8) @(posedge mclk_in);
    check(16'(secs), 16'd2, "seconds per half day");
    check({15'h0, meridiem_flag_out}, {15'h0, ~mer}, "meridiem toggle");
    end_of_test();
  end
endmodule : tb_scp_system_ctrl
`default_nettype wire
